/* testbench/tb_register_cell_clock_selection.sv */
// Self-checking bench for the register cell clock selection block
module tb_register_cell_clock_selection;
  import clock_select_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(got, exp) \
    begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
        num_errors++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
    end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic hw_clk = 1'b0; // Held low whenever the hardwired pin is unused
  logic clk_a = 1'b0;
  logic clk_b = 1'b0;
  logic test_rst = 1'b1;
  logic [1:0] int_clk = 2'h0;
  logic [19:0] comb_in = 20'h00000;
  logic [3:0] cell_q;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  register_cell_clock_selection #(.NUM_CELLS(4)) register_cell_clock_selection_i (
    .sys_clk_i(sys_clk),
    .sys_rst_i(sys_rst),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .hardwired_clock_i(hw_clk),
    .routed_clock_a_i(clk_a),
    .routed_clock_b_i(clk_b),
    .test_reset_i(test_rst),
    .internal_routed_clock_buffer_i(int_clk),
    .comb_in_i(comb_in),
    .cell_q_o(cell_q)
  );

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // Ends once pready is seen high; the bench hang guard ends it if pready never comes
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps two transfers from touching psel in one step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    // Extra edge so a new setting has reached the cell outputs
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, exp)
    `CHK(err, exp_err)
  endtask

  // Drive one clock pin and let the sampled edge reach the cell
  task automatic pin(input int s, input logic v);
    case (s)
      0: hw_clk <= v;
      1: clk_a <= v;
      2: clk_b <= v;
      3: int_clk[0] <= v;
      default: int_clk[1] <= v;
    endcase
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pulse(input int s);
    pin(s, 1'b1);
    pin(s, 1'b0);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    // Reset values, access kinds, refused accesses
    rd_chk(CTRL_OFF, 32'h0000_0000, 1'b0);
    rd_chk(CFG_BASE, 32'h0000_0000, 1'b0);
    rd_chk(LUT_BASE, 32'h0000_0000, 1'b0);
    wr(STATUS_OFF, 32'hffff_ffff);
    rd_chk(STATUS_OFF, 32'h0000_0000, 1'b0);
    rd_chk(8'hfc, 32'h0000_0000, 1'b1);
    wr(CTRL_OFF, 32'hffff_ffff);
    rd_chk(CTRL_OFF, 32'h0000_0007, 1'b0);
    wr(CFG_BASE + 8'h0c, 32'hffff_ffff);
    rd_chk(CFG_BASE + 8'h0c, 32'h0000_7fff, 1'b0);
    wr(CFG_BASE + 8'h0c, 32'h0000_0000);
    done("registers");

    // Start-up gate: bypass asked in CTRL but test reset pin high
    wr(CTRL_OFF, 32'h0000_0001);
    wr(CFG_BASE, 32'h0000_0008);
    wr(LUT_BASE, 32'hffff_ffff);
    repeat (3) pulse(0);
    `CHK(cell_q[0], 1'b0)
    rd_chk(STATUS_OFF, 32'h0000_0006, 1'b0);
    pulse(0);
    `CHK(cell_q[0], 1'b1)
    rd_chk(STATUS_OFF, 32'h0000_0107, 1'b0);
    done("startup");

    // Routed A, falling edge, from pin then from internal buffer
    wr(CTRL_OFF, 32'h0000_0000);
    wr(CFG_BASE + 8'h04, 32'h0000_000b);
    wr(LUT_BASE + 8'h04, 32'hffff_ffff);
    pin(1, 1'b1);
    `CHK(cell_q[1], 1'b0)
    pin(1, 1'b0);
    `CHK(cell_q[1], 1'b1)
    wr(CFG_BASE + 8'h04, 32'h0000_028b);
    `CHK(cell_q[1], 1'b0)
    wr(CFG_BASE + 8'h04, 32'h0000_008b);
    `CHK(cell_q[1], 1'b1)
    wr(CFG_BASE + 8'h04, 32'h0000_020b);
    wr(CFG_BASE + 8'h04, 32'h0000_000b);
    wr(CTRL_OFF, 32'h0000_0002);
    pin(3, 1'b1);
    `CHK(cell_q[1], 1'b0)
    pin(3, 1'b0);
    `CHK(cell_q[1], 1'b1)
    // Enable taken from the routed A level, which is low at its falling edge here
    wr(CFG_BASE + 8'h04, 32'h0000_0213);
    wr(CFG_BASE + 8'h04, 32'h0000_0013);
    pulse(3);
    `CHK(cell_q[1], 1'b0)
    wr(CTRL_OFF, 32'h0000_0000);
    done("routed_a");

    // Routed B, rising edge, combinatorial input with inversion
    comb_in[14:10] <= 5'b00001;
    wr(CFG_BASE + 8'h08, 32'h0000_000c);
    wr(LUT_BASE + 8'h08, 32'h0000_0002);
    pulse(2);
    `CHK(cell_q[2], 1'b1)
    wr(CFG_BASE + 8'h08, 32'h0000_080c);
    pulse(2);
    `CHK(cell_q[2], 1'b0)
    wr(CFG_BASE + 8'h08, 32'h0000_0004);
    wr(CFG_BASE + 8'h08, 32'h0000_0004);
    comb_in[14:10] <= 5'b00000;
    wr(LUT_BASE + 8'h08, 32'h0000_0001);
    pulse(2);
    `CHK(cell_q[2], 1'b0)
    // Routed B level as input 4, then the paired flop taking older data
    wr(CFG_BASE + 8'h08, 32'h0000_200c);
    wr(LUT_BASE + 8'h08, 32'h0001_0000);
    pulse(2);
    `CHK(cell_q[2], 1'b1)
    wr(CFG_BASE + 8'h08, 32'h0000_600c);
    pulse(2);
    `CHK(cell_q[2], 1'b0)
    // Routed B from the internal buffer, its pin held low
    wr(CTRL_OFF, 32'h0000_0004);
    wr(CFG_BASE + 8'h08, 32'h0000_000d);
    wr(LUT_BASE + 8'h08, 32'h0000_0001);
    pin(4, 1'b1);
    `CHK(cell_q[2], 1'b0)
    pin(4, 1'b0);
    `CHK(cell_q[2], 1'b1)
    wr(CTRL_OFF, 32'h0000_0000);
    done("routed_b");

    // Second reset: bypass with test reset pin tied low
    do_reset();
    `CHK(cell_q, 4'h0)
    test_rst <= 1'b0;
    wr(CTRL_OFF, 32'h0000_0001);
    wr(CFG_BASE, 32'h0000_0008);
    wr(LUT_BASE, 32'hffff_ffff);
    pulse(0);
    `CHK(cell_q[0], 1'b1)
    done("bypass");
    final_report();
  end
endmodule

/* verilog/clock_select_pkg.sv */
// Constants shared by the register cell clock selection block
package clock_select_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] CFG_BASE = 8'h10;
  localparam logic [7:0] LUT_BASE = 8'h30;
  localparam int unsigned MAX_CELLS = 8;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_TRST_RSV = 0;
  localparam int unsigned CTRL_A_INT = 1;
  localparam int unsigned CTRL_B_INT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_LIVE = 0;
  localparam int unsigned ST_CNT_LSB = 1;
  localparam int unsigned ST_CELLS_LSB = 8;

  // ----------------------------------------------------------------
  // Cell configuration fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_W = 15;
  localparam int unsigned CFG_POL = 0;
  localparam int unsigned CFG_SRC_LSB = 1;
  localparam int unsigned CFG_S0_LSB = 3;
  localparam int unsigned CFG_S1_LSB = 5;
  localparam int unsigned CFG_ASYNC_PRESET_INPUT_LSB = 7;
  localparam int unsigned CFG_CLR_LSB = 9;
  localparam int unsigned CFG_INV = 11;
  localparam int unsigned CFG_A_IN = 12;
  localparam int unsigned CFG_B_IN = 13;
  localparam int unsigned CFG_PAIRED = 14;
  localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;
  localparam logic [DATA_W-1:0] LUT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Combinatorial cell
  // ----------------------------------------------------------------
  localparam int unsigned COMB_IN_W = 5;
  localparam int unsigned COMB_A_POS = 3;
  localparam int unsigned COMB_B_POS = 4;

  // ----------------------------------------------------------------
  // Start-up suppression of the hardwired clock
  // ----------------------------------------------------------------
  localparam int unsigned STARTUP_EDGES = 4;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'(STARTUP_EDGES - 1);

  // Register clock source
  typedef enum logic [1:0] {
    SRC_HARDWIRED,
    SRC_ROUTED_A,
    SRC_ROUTED_B,
    SRC_UNUSED
  } clk_src_t;

  // Source of an enable, preset or clear line
  typedef enum logic [1:0] {
    CTL_LOW,
    CTL_HIGH,
    CTL_ROUTED_A,
    CTL_ROUTED_B
  } ctl_src_t;

endpackage

/* verilog/register_cell.sv */
// One register cell flop with clear, preset, enable and paired mode
module register_cell
  import clock_select_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic edge_i,
  input wire logic enable_select_zero_i,
  input wire logic enable_select_one_i,
  input wire logic async_preset_input_i,
  input wire logic async_clear_input_i,
  input wire logic paired_i,
  input wire logic d_i,
  output logic q_o
);

  logic q_q, q_d;
  logic master_q, master_d;
  logic load;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Clear wins over preset; both act without waiting for a cell edge
  always_comb
  begin
    load = edge_i && (enable_select_zero_i || enable_select_one_i); // [R1]
    master_d = d_i; // [R12]
    q_d = q_q;
    if (async_clear_input_i)
      q_d = 1'b0; // [R1]
    else if (async_preset_input_i)
      q_d = 1'b1; // [R1]
    else if (load)
      q_d = paired_i ? master_q : d_i; // [R12]
  end

  // Paired storage lags one system cycle, like the slower fabric path
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      q_q <= 1'b0;
      master_q <= 1'b0;
    end
    else
    begin
      q_q <= q_d;
      master_q <= master_d;
    end
  end

  assign q_o = q_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clear_wins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    async_clear_input_i |=> !q_o) else $error("clear did not force zero");
  a_preset_sets: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    !async_clear_input_i && async_preset_input_i |=> q_o) else $error("preset failed");
  a_hold_disabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    !async_clear_input_i && !async_preset_input_i && !(enable_select_zero_i
    || enable_select_one_i) |=> $stable(q_o)) else $error("disabled cell changed");
  a_edge_capture: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
    edge_i && enable_select_one_i && !paired_i && !async_clear_input_i
    && !async_preset_input_i |=> q_o == $past(d_i)) else $error("edge capture lost");
  a_paired_lag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R12]
    ##1 edge_i && enable_select_zero_i && paired_i && !async_clear_input_i
    && !async_preset_input_i |=> q_o == $past(d_i, 2)) else $error("paired flop wrong");

endmodule

/* verilog/register_cell_clock_selection.sv */
// Clock networks, start-up gating, combinatorial cells and register cells
// How it works
// [R1] Each cell flop has clear, preset and enable from two select lines.
// [R2] Each cell chooses rising or falling active edge on its own.
// [R3] Each cell picks hardwired or a routed network as its clock.
// [R4] Exactly three networks: one hardwired, two routed.
// [R5] Hardwired clock reaches only cell clock selection, never combinatorial logic.
// [R6] Hardwired edges are suppressed after reset until the fourth cycle.
// [R7] Reserved test reset tied low lets hardwired edges pass from the first; here CTRL bit 0 must also be set.
// [R8] Each routed network comes from its pin or the internal buffer.
// [R9] Routed networks feed cell clocks and combinatorial inputs alike.
// [R10] Board holds a routed pin fixed while that network is internal.
// [R11] Board ties every unused clock pin high or low.
// [R12] A cell can run as a paired combinatorial-cell flop.
// [R13] Combinatorial cell is a five-input function, one input invertible.
// [R14] Routed networks may drive cell enables, preset and clear.
// [R15] A counter of hardwired edges after reset opens the gate at four.
//
// The address map and register access over APB were decided locally.
module register_cell_clock_selection
  import clock_select_pkg::*;
#(
  parameter int unsigned NUM_CELLS = 4
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic hardwired_clock_i,
  input wire logic routed_clock_a_i,
  input wire logic routed_clock_b_i,
  input wire logic test_reset_i,
  input wire logic [1:0] internal_routed_clock_buffer_i,
  input wire logic [COMB_IN_W*NUM_CELLS-1:0] comb_in_i,
  output logic [NUM_CELLS-1:0] cell_q_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Level for an enable, preset or clear line
  function automatic logic pick_ctl(input logic [1:0] code, input logic a, input logic b);
    unique case (ctl_src_t'(code))
      CTL_LOW: pick_ctl = 1'b0;
      CTL_HIGH: pick_ctl = 1'b1;
      CTL_ROUTED_A: pick_ctl = a; // [R14]
      CTL_ROUTED_B: pick_ctl = b; // [R14]
    endcase
  endfunction

  // Edge of the selected network at the selected polarity
  function automatic logic pick_edge(input logic [1:0] src, input logic fall,
    input logic [5:0] edges);
    logic [1:0] e;
    e = 2'b00;
    unique case (clk_src_t'(src))
      SRC_HARDWIRED: e = edges[1:0];
      SRC_ROUTED_A: e = edges[3:2];
      SRC_ROUTED_B: e = edges[5:4];
      default: e = 2'b00;
    endcase
    pick_edge = fall ? e[1] : e[0]; // [R2]
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [CFG_W-1:0] cfg_q [NUM_CELLS];
  logic [CFG_W-1:0] cfg_d [NUM_CELLS];
  logic [DATA_W-1:0] lut_q [NUM_CELLS];
  logic [DATA_W-1:0] lut_d [NUM_CELLS];
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic hw_prev_q, a_prev_q, b_prev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic live_q, live_d;
  logic hit;
  logic [DATA_W-1:0] rd_word;
  logic level_a, level_b;
  logic hw_rise, hw_fall, hw_rise_g, hw_fall_g, bypass;
  logic [5:0] edges;
  logic [NUM_CELLS-1:0] cell_q, cell_edge, comb_out;
  logic [COMB_IN_W-1:0] comb_idx [NUM_CELLS];

  // ----------------------------------------------------------------
  // Clock networks
  // ----------------------------------------------------------------
  // Three networks only; hardwired edges go to cell selection alone
  always_comb
  begin
    level_a = ctrl_q[CTRL_A_INT] ? internal_routed_clock_buffer_i[0]
                                 : routed_clock_a_i; // [R8] [R4]
    level_b = ctrl_q[CTRL_B_INT] ? internal_routed_clock_buffer_i[1]
                                 : routed_clock_b_i; // [R8]
    hw_rise = hardwired_clock_i && !hw_prev_q;
    hw_fall = !hardwired_clock_i && hw_prev_q;
    bypass = ctrl_q[CTRL_TRST_RSV] && !test_reset_i; // [R7]
    hw_rise_g = hw_rise && (live_q || bypass || cnt_q == CNT_LAST); // [R6]
    hw_fall_g = hw_fall && (live_q || bypass); // [R6]
    edges = {!level_b && b_prev_q, level_b && !b_prev_q,
             !level_a && a_prev_q, level_a && !a_prev_q,
             hw_fall_g, hw_rise_g}; // [R5]
  end

  // ----------------------------------------------------------------
  // Start-up counter
  // ----------------------------------------------------------------
  // Counter saturates once live, so it costs no toggling afterwards
  always_comb
  begin
    cnt_d = cnt_q;
    live_d = live_q;
    if (hw_rise && !live_q)
    begin
      if (cnt_q == CNT_LAST)
        live_d = 1'b1; // [R15]
      else
        cnt_d = cnt_q + 3'h1; // [R15]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '0;
      live_q <= 1'b0;
      hw_prev_q <= 1'b0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      live_q <= live_d;
      hw_prev_q <= hardwired_clock_i;
      a_prev_q <= level_a;
      b_prev_q <= level_b;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always_comb
  begin
    hit = 1'b0;
    rd_word = '0;
    if (paddr_i == CTRL_OFF)
    begin
      hit = 1'b1;
      rd_word[CTRL_W-1:0] = ctrl_q;
    end
    if (paddr_i == STATUS_OFF)
    begin
      hit = 1'b1;
      rd_word[ST_LIVE] = live_q;
      rd_word[ST_CNT_LSB +: CNT_W] = cnt_q;
      rd_word[ST_CELLS_LSB +: NUM_CELLS] = cell_q;
    end
    for (int i = 0; i < NUM_CELLS; i++)
    begin
      if (paddr_i == CFG_BASE + 8'(4 * i))
      begin
        hit = 1'b1;
        rd_word[CFG_W-1:0] = cfg_q[i];
      end
      if (paddr_i == LUT_BASE + 8'(4 * i))
      begin
        hit = 1'b1;
        rd_word = lut_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state; writes land on the edge that samples pready high
  always_comb
  begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    lut_d = lut_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel_i && penable_i && !pready_q)
    begin
      pready_d = 1'b1;
      pslverr_d = !hit;
      prdata_d = (pwrite_i || !hit) ? '0 : rd_word;
    end
    if (psel_i && penable_i && pready_q && pwrite_i && hit)
    begin
      if (paddr_i == CTRL_OFF)
        ctrl_d = pwdata_i[CTRL_W-1:0];
      for (int i = 0; i < NUM_CELLS; i++)
      begin
        if (paddr_i == CFG_BASE + 8'(4 * i))
          cfg_d[i] = pwdata_i[CFG_W-1:0];
        if (paddr_i == LUT_BASE + 8'(4 * i))
          lut_d[i] = pwdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q <= CTRL_RST;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      for (int i = 0; i < NUM_CELLS; i++)
      begin
        cfg_q[i] <= CFG_RST;
        lut_q[i] <= LUT_RST;
      end
    end
    else
    begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cfg_q <= cfg_d;
      lut_q <= lut_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ----------------------------------------------------------------
  // Combinatorial cells and register cells
  // ----------------------------------------------------------------
  // Routed levels may replace two inputs; hardwired clock cannot
  always_comb
  begin
    for (int i = 0; i < NUM_CELLS; i++)
    begin
      comb_idx[i] = comb_in_i[COMB_IN_W*i +: COMB_IN_W];
      comb_idx[i][0] = comb_idx[i][0] ^ cfg_q[i][CFG_INV]; // [R13]
      if (cfg_q[i][CFG_A_IN])
        comb_idx[i][COMB_A_POS] = level_a; // [R9]
      if (cfg_q[i][CFG_B_IN])
        comb_idx[i][COMB_B_POS] = level_b; // [R9]
      comb_out[i] = lut_q[i][comb_idx[i]]; // [R13]
      cell_edge[i] = pick_edge(cfg_q[i][CFG_SRC_LSB +: 2], cfg_q[i][CFG_POL],
                               edges); // [R3] [R2]
    end
  end

  for (genvar g = 0; g < NUM_CELLS; g++)
  begin : g_cell
    register_cell register_cell_i (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .edge_i(cell_edge[g]),
      .enable_select_zero_i(pick_ctl(cfg_q[g][CFG_S0_LSB +: 2], level_a, level_b)),
      .enable_select_one_i(pick_ctl(cfg_q[g][CFG_S1_LSB +: 2], level_a, level_b)),
      .async_preset_input_i(pick_ctl(cfg_q[g][CFG_ASYNC_PRESET_INPUT_LSB +: 2], level_a, level_b)),
      .async_clear_input_i(pick_ctl(cfg_q[g][CFG_CLR_LSB +: 2], level_a, level_b)),
      .paired_i(cfg_q[g][CFG_PAIRED]),
      .d_i(comb_out[g]),
      .q_o(cell_q[g])
    );
  end

  assign cell_q_o = cell_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_early_edge: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R6]
    !live_q && !bypass && cnt_q != CNT_LAST |-> !edges[0] && !edges[1])
    else $error("hardwired edge passed too early");
  a_fourth_opens: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R15]
    hw_rise && !live_q && cnt_q == CNT_LAST |-> edges[0] ##1 live_q)
    else $error("fourth edge did not open gate");
  a_count_steps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R15]
    hw_rise && !live_q && cnt_q != CNT_LAST |=> cnt_q == $past(cnt_q) + 3'h1)
    else $error("start-up count did not step");
  a_bypass_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R7]
    ctrl_q[CTRL_TRST_RSV] && !test_reset_i && hw_rise |-> edges[0])
    else $error("bypass did not pass hardwired edge");
  a_routed_a_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R8]
    !ctrl_q[CTRL_A_INT] && !routed_clock_a_i ##1 !ctrl_q[CTRL_A_INT]
    && routed_clock_a_i |-> edges[2]) else $error("routed pin edge missed");
  a_routed_b_int: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R8]
    ctrl_q[CTRL_B_INT] && internal_routed_clock_buffer_i[1] ##1 ctrl_q[CTRL_B_INT]
    && !internal_routed_clock_buffer_i[1] |-> edges[5])
    else $error("internal routed edge missed");
  a_hw_select: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R3]
    cfg_q[0][CFG_SRC_LSB +: 2] == 2'h0 && !cfg_q[0][CFG_POL] |-> cell_edge[0] == edges[0])
    else $error("hardwired source not selected");
  a_apb_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    psel_i && penable_i && !pready_q |=> pready_q ##1 !pready_q)
    else $error("pready not a single pulse");

endmodule
